/* hw/asspi_crc.sv */
/*
 * Combinational 4-bit CRC, x^4+x+1, preset all ones, MSB first.
 * Assumes a 16-bit payload.
 */
`timescale 1ns/1ps
`default_nettype none

module asspi_crc
   import asspi_pkg::*;
(
   input wire logic [15:0] data,
   output logic [3:0] crc
);
   // ---------------------------------------------------------------
   // Unrolled LFSR, one step per payload bit
   // ---------------------------------------------------------------
   always_comb begin
      logic [3:0] c;
      logic inv;
      c = CRC_PRESET;
      inv = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         inv = data[i] ^ c[3];
         c = {c[2], c[1], c[0] ^ inv, inv};
      end
      crc = c;
   end
endmodule : asspi_crc

`default_nettype wire

/* hw/asspi_pkg.sv */
/*
 * Constants shared by the angle sensor SPI register port: register
 * byte addresses, command codes, frame lengths and timing counts.
 * Assumes a 10 MHz system clock.
 */
package asspi_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses (6-bit, even = high byte)
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_EWDH = 6'h04;
   localparam logic [5:0] ADDR_EWDL = 6'h06;
   localparam logic [5:0] ADDR_EXT_ADDR = 6'h0A;
   localparam logic [5:0] ADDR_EXT_RD = 6'h0C;
   localparam logic [5:0] ADDR_CTRL = 6'h1E;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   localparam logic [5:0] ADDR_WARN = 6'h22;
   localparam logic [5:0] ADDR_TD_HIGH = 6'h36;
   localparam logic [5:0] ADDR_TD_LOW = 6'h38;

   // ----------------------------------------------------------------
   // Control command codes and trigger key
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_TRESET = 4'h1;
   localparam logic [3:0] CMD_LOAD = 4'h3;
   localparam logic [3:0] CMD_TRANSPORT = 4'h6;
   localparam logic [3:0] CMD_EXT_WR = 4'h8;
   localparam logic [3:0] CMD_EXT_RD = 4'h9;
   localparam logic [7:0] CMD_KEY = 8'h46;

   // ----------------------------------------------------------------
   // Frame layout and lengths
   // ----------------------------------------------------------------
   localparam int CMD_LEAD_BIT = 15;
   localparam int CMD_RW_BIT = 14;
   localparam int CMD_ADDR_LSB = 8;
   localparam int ADDR_W = 6;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int CRC_W = 4;
   localparam int FRAME_W = 20;
   localparam logic [5:0] LEN_PLAIN = 6'h10;
   localparam logic [5:0] LEN_S17 = 6'h11;
   localparam logic [5:0] LEN_CRC = 6'h14;
   localparam logic [5:0] CNT_MAX = 6'h3F;
   localparam logic [3:0] CRC_PRESET = 4'hF;

   // ----------------------------------------------------------------
   // Turns register layout and flags
   // ----------------------------------------------------------------
   localparam int TD_W = 24;
   localparam int ANG_W = 12;
   localparam int LOAD_HI_W = 5;
   localparam int WARN_IER_BIT = 0;
   localparam int WARN_CRC_BIT = 1;
   localparam logic [2:0] SYNC_IDLE = 3'h6; // {sclk, cs_n, mosi}

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TM_LOW_US = 64;
   localparam int TM_LOW_CYC =
      (TM_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : asspi_pkg

/* hw/asspi_port.sv */
/*
 * Angle sensor primary register port behind a mode 3 SPI slave, with
 * turns register load/reset, transport mode and indirect extended
 * access. Assumes nonvolatile settings, angle data and supply-line
 * writes arrive on clk; SPI pins are asynchronous.
 */
// Behaviour
// - Reset command clears turns counter
// - Rotation register writable only by indirect load
// - Code 0x3 plus key 0x46 loads rotation
// - Policy 0x: copy value, keep accumulating
// - Policy 1x: snap to nearest matching angle
// - Code 0x6 then inputs low 64us: transport
// - Any SPI input high leaves transport
// - Shipping disable blocks transport mode
// - Memory lock rejects all writes
// - Supply link disable ignores supply commands
// - Extended memory reached indirectly via registers
// - Four-wire mode 3 SPI slave
// - Frames 16, 20, or allowed 17 bits
// - Extra clocks raise warning, clean frames not
// - MOSI captured on SCLK rising edge
// - Read data returned in next frame
// - All-zero frame reads address 0 as 0
// - CRC x^4+x+1, preset ones, MSB first
// - CRC appended on MISO beyond 16 bits
// - Bad inbound CRC discards frame, warns
// - Even address reads whole word, odd byte only
`timescale 1ns/1ps
`default_nettype none

module asspi_port
   import asspi_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic chip_select_n,
   output logic miso,
   output logic miso_oe,
   input wire logic system_stable,
   input wire logic [11:0] sensed_angle,
   input wire logic angle_step_valid,
   input wire logic [11:0] angle_step,
   input wire logic [1:0] start_policy,
   input wire logic extra_clock_frame_allow,
   input wire logic inbound_crc_enable,
   input wire logic supply_link_disable,
   input wire logic shipping_mode_disable,
   input wire logic nv_lock,
   input wire logic sl_wr_valid,
   input wire logic [5:0] sl_wr_addr,
   input wire logic [7:0] sl_wr_data,
   output logic ext_req,
   output logic ext_write,
   output logic [15:0] ext_addr,
   output logic [31:0] ext_wdata,
   input wire logic ext_done,
   input wire logic [15:0] ext_rdata,
   output logic transport_mode,
   output logic [23:0] turns_delta
);
   asspi_sync_if sy ();

   logic sclk_d_reg;
   logic cs_d_reg;
   logic [5:0] bit_cnt_reg;
   logic [15:0] cmd_reg;
   logic [3:0] crc_rx_reg;
   logic [19:0] tx_reg;
   logic [15:0] resp_reg;
   logic [15:0] ewdh_reg;
   logic [15:0] ewdl_reg;
   logic [15:0] ext_addr_reg;
   logic [15:0] ext_rd_reg;
   logic [3:0] special_reg;
   logic [1:0] warn_reg;
   logic [23:0] td_reg;
   logic [9:0] low_cnt_reg;
   logic tm_armed_reg;
   logic tm_reg;
   logic ext_req_reg;
   logic ext_write_reg;
   logic ext_busy_reg;

   // ---------------------------------------------------------------
   // Pin synchroniser and CRC units
   // ---------------------------------------------------------------
   asspi_sync u_sync (
      .clk(clk),
      .rst(rst),
      .sclk(sclk),
      .mosi(mosi),
      .chip_select_n(chip_select_n),
      .sy(sy.src)
   );

   wire [3:0] crc_tx;
   wire [3:0] crc_chk;
   asspi_crc u_crc_tx (.data(resp_reg), .crc(crc_tx));
   asspi_crc u_crc_rx (.data(cmd_reg), .crc(crc_chk));

   // ---------------------------------------------------------------
   // Edge and frame boundary detection
   // ---------------------------------------------------------------
   wire sclk_rise = sy.sclk_s & ~sclk_d_reg;
   wire sclk_fall = ~sy.sclk_s & sclk_d_reg;
   wire active = ~sy.cs_n_s;
   wire cs_fall = ~sy.cs_n_s & cs_d_reg;
   wire frame_end = sy.cs_n_s & ~cs_d_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_d_reg <= 1'b1;
         cs_d_reg <= 1'b1;
      end else begin
         sclk_d_reg <= sy.sclk_s;
         cs_d_reg <= sy.cs_n_s;
      end
   end

   // ---------------------------------------------------------------
   // Receive: bit counter and command/CRC capture
   // ---------------------------------------------------------------
   // Counter saturates so very long frames still read as too long
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_cnt_reg <= 6'h00;
         cmd_reg <= 16'h0000;
         crc_rx_reg <= 4'h0;
      end else if (cs_fall) begin
         bit_cnt_reg <= 6'h00;
      end else if (sclk_rise && active) begin
         if (bit_cnt_reg != CNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
         if (bit_cnt_reg < LEN_PLAIN) begin
            cmd_reg <= {cmd_reg[WORD_W-2:0], sy.mosi_s};
         end else if (bit_cnt_reg < LEN_CRC) begin
            crc_rx_reg <= {crc_rx_reg[CRC_W-2:0], sy.mosi_s};
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame evaluation at chip select release
   // ---------------------------------------------------------------
   wire len_17 = (bit_cnt_reg == LEN_S17);
   wire len_ok = (bit_cnt_reg == LEN_PLAIN) ||
      (bit_cnt_reg == LEN_CRC) || (len_17 && extra_clock_frame_allow);
   wire too_many = (bit_cnt_reg > LEN_PLAIN) && !len_ok;
   wire crc_bad = inbound_crc_enable && (bit_cnt_reg >= LEN_CRC) &&
      (crc_rx_reg != crc_chk);
   // A set lead bit marks a malformed frame; it is dropped
   wire accepted = frame_end && len_ok && !crc_bad &&
      !cmd_reg[CMD_LEAD_BIT];
   wire is_write = cmd_reg[CMD_RW_BIT];
   wire spi_wr = accepted && is_write;
   wire rd_take = accepted && !is_write;
   wire [5:0] rd_addr = cmd_reg[CMD_ADDR_LSB+ADDR_W-1:CMD_ADDR_LSB];

   // ---------------------------------------------------------------
   // Write port: SPI first, then supply line
   // ---------------------------------------------------------------
   // Supply-line write loses a same-cycle collision with SPI
   wire sl_ok = sl_wr_valid && !supply_link_disable;
   wire wr_en = (spi_wr || sl_ok) && !nv_lock;
   wire [5:0] wr_addr = spi_wr ? rd_addr : sl_wr_addr;
   wire [7:0] wr_data = spi_wr ? cmd_reg[BYTE_W-1:0] : sl_wr_data;
   wire wr_hi = wr_en && !wr_addr[0];
   wire wr_lo = wr_en && wr_addr[0];
   wire [4:0] wr_word = wr_addr[ADDR_W-1:1];

   wire hit_ewdh = (wr_word == ADDR_EWDH[ADDR_W-1:1]);
   wire hit_ewdl = (wr_word == ADDR_EWDL[ADDR_W-1:1]);
   wire hit_exta = (wr_word == ADDR_EXT_ADDR[ADDR_W-1:1]);
   wire hit_ctrl = (wr_word == ADDR_CTRL[ADDR_W-1:1]);

   // Key byte (even) fires the command already held in the odd byte
   wire fire = wr_hi && hit_ctrl && (wr_data == CMD_KEY);
   wire cmd_load = fire && (special_reg == CMD_LOAD);
   wire cmd_treset = fire && (special_reg == CMD_TRESET);
   wire cmd_ext_wr = fire && (special_reg == CMD_EXT_WR);
   wire cmd_ext_rd = fire && (special_reg == CMD_EXT_RD);
   wire tm_arm = wr_lo && hit_ctrl &&
      (wr_data[CRC_W-1:0] == CMD_TRANSPORT);

   // Extended write data and address registers, byte writable
   always_ff @(posedge clk) begin
      if (rst) begin
         ewdh_reg <= 16'h0000;
         ewdl_reg <= 16'h0000;
         ext_addr_reg <= 16'h0000;
         special_reg <= 4'h0;
      end else begin
         if (wr_hi && hit_ewdh) ewdh_reg[15:8] <= wr_data;
         if (wr_lo && hit_ewdh) ewdh_reg[7:0] <= wr_data;
         if (wr_hi && hit_ewdl) ewdl_reg[15:8] <= wr_data;
         if (wr_lo && hit_ewdl) ewdl_reg[7:0] <= wr_data;
         if (wr_hi && hit_exta) ext_addr_reg[15:8] <= wr_data;
         if (wr_lo && hit_exta) ext_addr_reg[7:0] <= wr_data;
         if (wr_lo && hit_ctrl) special_reg <= wr_data[CRC_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Turns register: reset, indirect load, accumulation
   // ---------------------------------------------------------------
   // No write address decodes to the turns register, so it is never
   // written directly
   wire [23:0] load_val = {{(TD_W-WORD_W-LOAD_HI_W){ewdh_reg[4]}},
      ewdh_reg[LOAD_HI_W-1:0], ewdl_reg};
   wire [11:0] snap_diff = sensed_angle - load_val[ANG_W-1:0];
   wire [23:0] td_snap = load_val +
      {{(TD_W-ANG_W){snap_diff[ANG_W-1]}}, snap_diff};
   wire [23:0] td_step = td_reg +
      {{(TD_W-ANG_W){angle_step[ANG_W-1]}}, angle_step};
   wire [23:0] td_clr = {{(TD_W-ANG_W){1'b0}}, td_reg[ANG_W-1:0]};
   wire [23:0] td_load = start_policy[1] ? td_snap : load_val;
   wire [23:0] td_next = cmd_treset ? td_clr :
      cmd_load ? td_load :
      angle_step_valid ? td_step : td_reg;

   always_ff @(posedge clk) begin
      if (rst) td_reg <= 24'h000000;
      else td_reg <= td_next;
   end

   // ---------------------------------------------------------------
   // Extended memory request handshake
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_req_reg <= 1'b0;
         ext_write_reg <= 1'b0;
         ext_busy_reg <= 1'b0;
         ext_rd_reg <= 16'h0000;
      end else begin
         ext_req_reg <= cmd_ext_wr || cmd_ext_rd;
         if (cmd_ext_wr || cmd_ext_rd) ext_write_reg <= cmd_ext_wr;
         if (cmd_ext_wr || cmd_ext_rd) ext_busy_reg <= 1'b1;
         else if (ext_done) ext_busy_reg <= 1'b0;
         if (ext_done) ext_rd_reg <= ext_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Warning flags: set wins over clear-on-read
   // ---------------------------------------------------------------
   wire warn_rd = rd_take && (rd_addr[ADDR_W-1:1] ==
      ADDR_WARN[ADDR_W-1:1]);
   wire set_ier = frame_end && too_many;
   wire set_crc = frame_end && crc_bad;

   always_ff @(posedge clk) begin
      if (rst) warn_reg <= 2'h0;
      else begin
         warn_reg[WARN_IER_BIT] <= set_ier ||
            (warn_reg[WARN_IER_BIT] && !warn_rd);
         warn_reg[WARN_CRC_BIT] <= set_crc ||
            (warn_reg[WARN_CRC_BIT] && !warn_rd);
      end
   end

   // ---------------------------------------------------------------
   // Read multiplexer and pipelined response
   // ---------------------------------------------------------------
   wire [4:0] rd_word = rd_addr[ADDR_W-1:1];
   wire [15:0] status_w = {13'h0000, ext_busy_reg, tm_armed_reg,
      system_stable};
   wire [15:0] word_sel =
      (rd_word == ADDR_EWDH[ADDR_W-1:1]) ? ewdh_reg :
      (rd_word == ADDR_EWDL[ADDR_W-1:1]) ? ewdl_reg :
      (rd_word == ADDR_EXT_ADDR[ADDR_W-1:1]) ? ext_addr_reg :
      (rd_word == ADDR_EXT_RD[ADDR_W-1:1]) ? ext_rd_reg :
      (rd_word == ADDR_CTRL[ADDR_W-1:1]) ? {12'h000, special_reg} :
      (rd_word == ADDR_STATUS[ADDR_W-1:1]) ? status_w :
      (rd_word == ADDR_WARN[ADDR_W-1:1]) ? {14'h0000, warn_reg} :
      (rd_word == ADDR_TD_HIGH[ADDR_W-1:1]) ?
         {4'h0, td_reg[TD_W-1:ANG_W]} :
      (rd_word == ADDR_TD_LOW[ADDR_W-1:1]) ?
         {4'h0, td_reg[ANG_W-1:0]} :
      16'h0000;
   wire [15:0] rd_value = rd_addr[0] ?
      {8'h00, word_sel[BYTE_W-1:0]} : word_sel;

   // Writes answer zero next frame; host discards that
   always_ff @(posedge clk) begin
      if (rst) resp_reg <= 16'h0000;
      else if (accepted) resp_reg <= rd_take ? rd_value : 16'h0000;
   end

   // ---------------------------------------------------------------
   // Transmit shifter, shifted on falling SCLK after first bit
   // ---------------------------------------------------------------
   // First bit stands from chip select fall, before any clock
   always_ff @(posedge clk) begin
      if (rst) tx_reg <= 20'h00000;
      else if (cs_fall) tx_reg <= {resp_reg, crc_tx};
      else if (sclk_fall && active && bit_cnt_reg != 6'h00) begin
         tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
      end
   end

   assign miso = tx_reg[FRAME_W-1];
   assign miso_oe = active;

   // ---------------------------------------------------------------
   // Transport mode: armed by command, entered on long idle
   // ---------------------------------------------------------------
   wire any_high = sy.sclk_s || sy.mosi_s || sy.cs_n_s;
   wire low_done = (low_cnt_reg == 10'(TM_LOW_CYC));

   always_ff @(posedge clk) begin
      if (rst || any_high) low_cnt_reg <= 10'h000;
      else if (!low_done) low_cnt_reg <= low_cnt_reg + 10'h001;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tm_armed_reg <= 1'b0;
         tm_reg <= 1'b0;
      end else begin
         if (tm_arm && !shipping_mode_disable) tm_armed_reg <= 1'b1;
         else if (tm_reg && any_high) tm_armed_reg <= 1'b0;
         if (any_high) tm_reg <= 1'b0;
         else if (tm_armed_reg && low_done && !shipping_mode_disable)
            tm_reg <= 1'b1;
      end
   end

   assign transport_mode = tm_reg;
   assign turns_delta = td_reg;
   assign ext_req = ext_req_reg;
   assign ext_write = ext_write_reg;
   assign ext_addr = ext_addr_reg;
   assign ext_wdata = {ewdh_reg, ewdl_reg};

   // ---------------------------------------------------------------
   // Assertions and covers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_turns_reset_clr: assert property (cmd_treset |=>
      td_reg[TD_W-1:ANG_W] == 12'h000) else $error("turns not cleared");
   a_load_copy_val: assert property (cmd_load && !start_policy[1]
      |=> td_reg == $past(load_val)) else $error("load copy wrong");
   a_load_snap_ang: assert property (cmd_load && start_policy[1]
      && !cmd_treset |=> td_reg[ANG_W-1:0] == $past(sensed_angle))
      else $error("snap angle wrong");
   a_lock_no_write: assert property (nv_lock |-> !wr_en)
      else $error("write under lock");
   a_sl_disable_ign: assert property (supply_link_disable && !spi_wr
      |-> !wr_en) else $error("supply write taken");
   a_tm_no_ship: assert property (!tm_reg && shipping_mode_disable
      |=> !tm_reg) else $error("transport while disabled");
   a_tm_wake_exit: assert property (tm_reg && any_high |=> !tm_reg)
      else $error("no wake from transport");
   a_tm_enter_idle: assert property ($rose(tm_reg) |->
      $past(low_done) && $past(tm_armed_reg))
      else $error("transport entered early");
   a_ier_on_extra: assert property (frame_end && too_many |=>
      warn_reg[WARN_IER_BIT]) else $error("extra clock missed");
   a_ier_clean: assert property (frame_end && len_ok && !warn_reg[0]
      && !warn_rd |=> !warn_reg[WARN_IER_BIT])
      else $error("clean frame warned");
   a_crc_discard: assert property (frame_end && crc_bad |->
      !spi_wr && !rd_take ##1 warn_reg[WARN_CRC_BIT])
      else $error("bad crc frame used");
   a_first_bit_out: assert property (cs_fall |=>
      miso == $past(resp_reg[WORD_W-1]))
      else $error("first miso bit wrong");

   c_frame_20: cover property (frame_end && bit_cnt_reg == LEN_CRC);
   c_load_cmd: cover property (cmd_load);
   c_tm_entry: cover property ($rose(tm_reg));
   c_pipe_read: cover property (rd_take ##[1:200] rd_take);
endmodule : asspi_port

`default_nettype wire

/* hw/asspi_sync.sv */
/*
 * Two-flop synchroniser for the three SPI input pins.
 * Assumes the pins are asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module asspi_sync
   import asspi_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic chip_select_n,
   asspi_sync_if.src sy
);
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;

   // ---------------------------------------------------------------
   // Pin synchronisers, reset to idle bus levels
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= SYNC_IDLE;
         s2_reg <= SYNC_IDLE;
      end else begin
         s1_reg <= {sclk, chip_select_n, mosi};
         s2_reg <= s1_reg;
      end
   end

   // Only the second stage is visible to the port logic
   assign sy.sclk_s = s2_reg[2];
   assign sy.cs_n_s = s2_reg[1];
   assign sy.mosi_s = s2_reg[0];
endmodule : asspi_sync

`default_nettype wire

/* hw/asspi_sync_if.sv */
/*
 * Synchronised SPI pin levels passed from the pin synchroniser to the
 * port logic. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface asspi_sync_if;
   logic sclk_s;
   logic mosi_s;
   logic cs_n_s;
   modport src (output sclk_s, output mosi_s, output cs_n_s);
   modport dst (input sclk_s, input mosi_s, input cs_n_s);
endinterface : asspi_sync_if

`default_nettype wire

/* verif/angle_sensor_spi_host_port_tb.sv */
/*
 * Self-checking bench for the angle sensor SPI register port.
 * Assumes the host model above and the register map of the package.
 */
`timescale 1ns/1ps
`default_nettype none

module angle_sensor_spi_host_port_tb;
   import asspi_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus, checking and closing
   // ---------------------------------------------------------------
   logic clk, rst, sclk, mosi, cs_n, miso, stable, step_v, allow, crc_en;
   logic sl_dis, ship_dis, lock, sl_v, tm;
   logic [1:0] policy;
   logic [11:0] angle, step;
   logic [23:0] turns;
   logic [19:0] rx;
   int err_count, checks;

   asspi_host_model hm (.sclk(sclk), .mosi(mosi), .chip_select_n(cs_n),
      .miso(miso));
   asspi_port dut (.clk(clk), .rst(rst), .sclk(sclk), .mosi(mosi),
      .chip_select_n(cs_n), .miso(miso), .miso_oe(),
      .system_stable(stable), .sensed_angle(angle),
      .angle_step_valid(step_v), .angle_step(step),
      .start_policy(policy), .extra_clock_frame_allow(allow),
      .inbound_crc_enable(crc_en), .supply_link_disable(sl_dis),
      .shipping_mode_disable(ship_dis), .nv_lock(lock),
      .sl_wr_valid(sl_v), .sl_wr_addr(ADDR_EWDL), .sl_wr_data(8'h77),
      .ext_req(), .ext_write(), .ext_addr(), .ext_wdata(),
      .ext_done(1'b0), .ext_rdata(16'h0000), .transport_mode(tm),
      .turns_delta(turns));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      hm.frame({2'b01, a, d}, 16, rx);
   endtask : wr

   // Read a, then fetch its answer with an all-zero frame
   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      hm.frame({2'b00, a, 8'h00}, 16, rx);
      hm.frame(16'h0000, 16, rx);
      chk(rx[15:0], exp);
   endtask : rd

   // Arm transport, hold all pins low past the quiet time, then wake
   task automatic tport(input logic exp);
      wr(6'h1F, {4'h0, CMD_TRANSPORT});
      hm.park();
      #70000;
      chk(tm, exp);
      hm.wake();
      chk(tm, 1'b0);
   endtask : tport

   task automatic tally_and_finish();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Watchdog: the tests need well under a millisecond
   initial begin
      #3000000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      {rst, stable, step_v, allow, crc_en, sl_dis, ship_dis} = 7'h60;
      {lock, sl_v, policy, angle, step} = 28'h0000000;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      wr(6'h04, 8'h00);
      wr(6'h05, 8'h01);
      wr(ADDR_EWDL, 8'hD0);
      wr(6'h07, 8'h0F);
      rd(ADDR_EWDL, 16'hD00F);
      rd(6'h07, 16'h000F);
      hm.frame({2'b00, ADDR_EWDL, 8'h00}, 20, rx);
      hm.frame(16'h0000, 20, rx);
      chk(rx, {16'hD00F, hm.crc4(16'hD00F)});
      @(negedge clk) lock = 1'b1;
      wr(ADDR_EWDL, 8'h55);
      @(negedge clk) lock = 1'b0;
      rd(ADDR_EWDL, 16'hD00F);
      @(negedge clk) sl_dis = 1'b1;
      sl_v = 1'b1;
      @(negedge clk) sl_v = 1'b0;
      rd(ADDR_EWDL, 16'hD00F);
      wr(6'h1F, {4'h0, CMD_LOAD});
      wr(ADDR_CTRL, CMD_KEY);
      chk(turns, 24'h01D00F);
      @(negedge clk) {step_v, step} = 13'h1001;
      @(negedge clk) step_v = 1'b0;
      @(negedge clk) chk(turns, 24'h01D010);
      @(negedge clk) {policy, angle} = 14'h2FF0;
      wr(ADDR_CTRL, CMD_KEY);
      chk(turns, 24'h01CFF0);
      wr(6'h1F, {4'h0, CMD_TRESET});
      wr(ADDR_CTRL, CMD_KEY);
      chk(turns, 24'h000FF0);
      hm.frame(16'h0000, 18, rx);
      rd(ADDR_WARN, 16'h0001);
      @(negedge clk) allow = 1'b1;
      hm.frame(16'h0000, 17, rx);
      rd(ADDR_WARN, 16'h0000);
      @(negedge clk) crc_en = 1'b1;
      hm.crc_flip = 4'h1;
      hm.frame({2'b01, ADDR_EWDL, 8'h99}, 20, rx);
      hm.crc_flip = 4'h0;
      rd(ADDR_EWDL, 16'hD00F);
      rd(ADDR_WARN, 16'h0002);
      @(negedge clk) crc_en = 1'b0;
      @(negedge clk) ship_dis = 1'b1;
      tport(1'b0);
      @(negedge clk) ship_dis = 1'b0;
      tport(1'b1);
      tally_and_finish();
   end
endmodule : angle_sensor_spi_host_port_tb

`default_nettype wire

/* verif/asspi_host_model.sv */
/*
 * Host side of the angle sensor SPI port: a mode 3 master model.
 * Assumes a link far slower than the system clock (800 ns period).
 */
`timescale 1ns/1ps
`default_nettype none

module asspi_host_model (
   output logic sclk,
   output logic mosi,
   output logic chip_select_n,
   input wire logic miso
);
   // Bits flipped into the sent check bits to provoke a CRC fault
   logic [3:0] crc_flip;

   // ---------------------------------------------------------------
   // Idle levels and frame tasks
   // ---------------------------------------------------------------
   initial begin
      crc_flip = 4'h0;
      sclk = 1'b1;
      mosi = 1'b0;
      chip_select_n = 1'b1;
   end

   // Check bits over the 16-bit payload, C3 out first
   function automatic logic [3:0] crc4(input logic [15:0] d);
      logic [3:0] c;
      logic inv;
      c = 4'hF;
      for (int i = 15; i >= 0; i--) begin
         inv = d[i] ^ c[3];
         c = {c[2:1], c[0] ^ inv, inv};
      end
      return c;
   endfunction : crc4

   // One frame of n bits, MSB first; data changes on the falling edge
   task automatic frame(input logic [15:0] cmd, input int n,
         output logic [19:0] rx);
      logic [19:0] w;
      w = {cmd, crc4(cmd) ^ crc_flip};
      rx = 20'h00000;
      chip_select_n = 1'b0;
      #800;
      for (int i = 19; i > 19 - n; i--) begin
         sclk = 1'b0;
         mosi = w[i];
         #400;
         sclk = 1'b1;
         rx = {rx[18:0], miso};
         #400;
      end
      chip_select_n = 1'b1;
      mosi = ~mosi; // Released line must not keep a stale level
      #1000;
   endtask : frame

   // All pins low: the idle state that leads toward low power
   task automatic park();
      sclk = 1'b0;
      mosi = 1'b0;
      chip_select_n = 1'b0;
   endtask : park

   // Any pin high wakes the device; a one-bit frame is then dropped
   task automatic wake();
      sclk = 1'b1;
      #1000;
      chip_select_n = 1'b1;
      #1000;
   endtask : wake
endmodule : asspi_host_model

`default_nettype wire
